// [ccp_compare_and_pwm.v]
// Top of the two-unit compare/PWM block with its register port
//
// Operation
// (R01) Compare value continuously matched against selected timer
// (R02) Match drives high, low, toggles or leaves pin
// (R03) Every match sets flag with pin action
// (R04) Zero control write forces output latch low
// (R05) Software runs time base synchronously
// (R06) Soft-interrupt mode only sets flag, gated by enable
// (R07) Special trigger resets the selected timer
// (R08) Second unit trigger starts enabled converter
// (R09) First unit trigger never starts conversion
// (R10) PWM output with 10-bit duty resolution
// (R11) Software makes the pin an output
// (R12) Period timer clears after matching period limit
// (R13) Rollover sets pin unless duty is zero
// (R14) Rollover copies duty into buffer registers
// (R15) Duty is low byte plus control bits 5:4
// (R16) High time is duty times tick times prescale
// (R17) Duty writes apply next period, buffer read-only
// (R18) Duty double-buffered against glitches
// (R19) Pin clears when buffer equals extended timer
// (R20) Duty beyond period keeps pin high
// (R21) Resolution is log2 of clock over PWM frequency
// (R22) Second timer control bits pick time bases
// (R23) Both PWMs share one period timer
// (R24) Period is limit plus one, times four, prescaled
// (R25) Mode codes fixed for high, low, toggle, PWM
`timescale 1ns/1ps
module ccp_compare_and_pwm #(
  parameter PRESCALE = 1 // Period timer prescale: 1, 4 or 16
) (
  input wire i_clk_sys, // System clock 100 MHz
  input wire i_rst_n, // Sync reset, active low
  input wire i_ce, // Clock enable, freezes all state
  input wire [3:0] i_addr, // Register address
  input wire [7:0] i_wdata, // Write data
  input wire i_wr, // Write strobe
  input wire i_rd, // Read strobe
  output reg [7:0] o_rdata, // Read data, cycle after strobe
  input wire [15:0] i_timer1, // First 16-bit timer count
  input wire [15:0] i_timer3, // Second 16-bit timer count
  input wire i_adc_enabled, // Converter already on
  input wire i_port_latch1, // I/O latch of first pin
  input wire i_port_latch2, // I/O latch of second pin
  output wire o_timer1_reset, // Reset pulse to first timer
  output wire o_timer3_reset, // Reset pulse to second timer
  output wire o_adc_start, // Conversion start pulse
  output wire o_irq, // Enabled flag request level
  output wire o_first_unit, // First unit output pin
  output wire o_second_unit // Second unit output pin
);
`include "ccp_consts.vh"

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] u1_lo;
  reg [7:0] u1_hi;
  reg [7:0] unit1_control_reg;
  reg [7:0] unit2_duty_low_byte;
  reg [7:0] u2_hi;
  reg [7:0] unit2_control_reg;
  reg [7:0] flags;
  reg [7:0] enables;
  reg [7:0] prio_bits;
  reg [7:0] second_timer_ctrl;
  reg [7:0] period_limit_reg;
  reg [7:0] period_timer;
  reg [1:0] phase;
  reg [3:0] pre_cnt;
  reg u1_zero;
  reg u2_zero;

  wire [3:0] mode1 = unit1_control_reg[3:0];
  wire [3:0] unit2_mode_field = unit2_control_reg[3:0];
  wire pwm1 = (mode1 == `MODE_PWM);
  wire pwm2 = (unit2_mode_field == `MODE_PWM);
  wire [15:0] unit1_compare_value = {u1_hi, u1_lo};
  wire [15:0] unit2_compare_value = {u2_hi, unit2_duty_low_byte};
  wire [7:0] buf1;
  wire [7:0] buf2;

  // ----------------------------------------------------------------
  // Time base selection
  // ----------------------------------------------------------------
  // Select code: 1x both on second timer, 01 unit2 on second, 00 both on first
  wire timebase_select_hi = second_timer_ctrl[`T3_SEL_HI];
  wire timebase_select_lo = second_timer_ctrl[`T3_SEL_LO];
  wire u1_on_t3 = timebase_select_hi; // (R22)
  wire u2_on_t3 = timebase_select_hi | timebase_select_lo; // (R22)
  wire [15:0] tb1 = u1_on_t3 ? i_timer3 : i_timer1;
  wire [15:0] tb2 = u2_on_t3 ? i_timer3 : i_timer1;

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  wire match1;
  wire match2;
  wire trig1;
  wire trig2;
  wire latch1;
  wire latch2;

  ccp_compare_unit cmp1 (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_mode(mode1),
    .i_ctrl_zero(u1_zero),
    .i_value(unit1_compare_value),
    .i_timer(tb1),
    .o_match(match1),
    .o_trigger(trig1),
    .o_latch(latch1)
  );

  ccp_compare_unit cmp2 (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_mode(unit2_mode_field),
    .i_ctrl_zero(u2_zero),
    .i_value(unit2_compare_value),
    .i_timer(tb2),
    .o_match(match2),
    .o_trigger(trig2),
    .o_latch(latch2)
  );

  // Trigger routing; only the second unit may start a conversion
  assign o_timer1_reset = (trig1 & ~u1_on_t3) | (trig2 & ~u2_on_t3); // (R07)
  assign o_timer3_reset = (trig1 & u1_on_t3) | (trig2 & u2_on_t3); // (R07)
  assign o_adc_start = trig2 & i_adc_enabled; // (R08) (R09)

  // ----------------------------------------------------------------
  // Shared period timer
  // ----------------------------------------------------------------
  // Prescaled tick every four times PRESCALE system cycles; both PWMs share it (R23)
  wire [3:0] pre_max = PRESCALE[3:0] - 4'h1;
  wire tick = (phase == 2'h3) && (pre_cnt == pre_max);
  wire rollover = tick && (period_timer == period_limit_reg); // (R12) (R24)
  // Count of the coming cycle: the pin then falls after exactly duty steps (R16)
  wire [1:0] next_phase = phase + 2'h1;
  wire [3:0] next_pre = (phase != 2'h3) ? pre_cnt : (pre_cnt == pre_max) ? 4'h0 : pre_cnt + 4'h1;
  wire [7:0] next_ptimer = rollover ? `RST_BYTE : tick ? period_timer + 8'h01 : period_timer;
  wire [1:0] low_bits = (PRESCALE == 1) ? next_phase : next_pre[3:2]; // (R19)
  wire [9:0] ext_count = {next_ptimer, (PRESCALE == 4) ? next_pre[1:0] : low_bits};

  // Period counting, (R21) follows from this count structure
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      phase <= 2'h0;
      pre_cnt <= 4'h0;
      period_timer <= `RST_BYTE;
    end else if (i_ce) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        pre_cnt <= (pre_cnt == pre_max) ? 4'h0 : pre_cnt + 4'h1;
      end
      if (rollover) begin
        period_timer <= `RST_BYTE; // (R12)
      end else if (tick) begin
        period_timer <= period_timer + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // PWM channels
  // ----------------------------------------------------------------
  wire pwm_pin1;
  wire pwm_pin2;

  ccp_pwm_unit pwm_a (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_enable(pwm1),
    .i_ctrl_zero(u1_zero),
    .i_duty({u1_lo, unit1_control_reg[`CTRL_DUTY_HI:`CTRL_DUTY_LO]}), // (R15)
    .i_rollover(rollover),
    .i_count(ext_count),
    .o_duty_buf(buf1),
    .o_pin(pwm_pin1)
  );

  ccp_pwm_unit pwm_b (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_enable(pwm2),
    .i_ctrl_zero(u2_zero),
    .i_duty({unit2_duty_low_byte, unit2_control_reg[`CTRL_DUTY_HI:`CTRL_DUTY_LO]}), // (R15)
    .i_rollover(rollover),
    .i_count(ext_count),
    .o_duty_buf(buf2),
    .o_pin(pwm_pin2)
  );

  // Pin mux; off and soft-irq modes show the plain I/O latch
  function pin_sel;
    input [3:0] m;
    input pl;
    input cl;
    input pw;
    begin
      if (m == `MODE_PWM) begin
        pin_sel = pw; // (R10)
      end else if (m == `MODE_SET_HIGH || m == `MODE_SET_LOW || m == `MODE_TOGGLE) begin
        pin_sel = cl;
      end else begin
        pin_sel = pl;
      end
    end
  endfunction

  assign o_first_unit = pin_sel(mode1, i_port_latch1, latch1, pwm_pin1);
  assign o_second_unit = pin_sel(unit2_mode_field, i_port_latch2, latch2, pwm_pin2);
  assign o_irq = |(flags & enables); // (R06)

  // ----------------------------------------------------------------
  // Register writes and flags
  // ----------------------------------------------------------------
  // Set beats a software clear in the same cycle
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      u1_lo <= `RST_BYTE;
      u1_hi <= `RST_BYTE;
      unit1_control_reg <= `RST_BYTE;
      unit2_duty_low_byte <= `RST_BYTE;
      u2_hi <= `RST_BYTE;
      unit2_control_reg <= `RST_BYTE;
      flags <= `RST_BYTE;
      enables <= `RST_BYTE;
      prio_bits <= `RST_BYTE;
      second_timer_ctrl <= `RST_BYTE;
      period_limit_reg <= `RST_PERIOD;
      u1_zero <= 1'b0;
      u2_zero <= 1'b0;
    end else if (i_ce) begin
      u1_zero <= i_wr && i_addr == `OFS_U1_CTRL && i_wdata == 8'h00; // (R04)
      u2_zero <= i_wr && i_addr == `OFS_U2_CTRL && i_wdata == 8'h00; // (R04)
      if (i_wr) begin
        if (i_addr == `OFS_U1_VAL_LO) begin
          u1_lo <= i_wdata;
        end else if (i_addr == `OFS_U1_VAL_HI && !pwm1) begin
          u1_hi <= i_wdata; // (R17)
        end else if (i_addr == `OFS_U1_CTRL) begin
          unit1_control_reg <= {2'b00, i_wdata[5:0]};
        end else if (i_addr == `OFS_U2_VAL_LO) begin
          unit2_duty_low_byte <= i_wdata;
        end else if (i_addr == `OFS_U2_VAL_HI && !pwm2) begin
          u2_hi <= i_wdata; // (R17)
        end else if (i_addr == `OFS_U2_CTRL) begin
          unit2_control_reg <= {2'b00, i_wdata[5:0]};
        end else if (i_addr == `OFS_ENABLES) begin
          enables <= i_wdata & 8'h06;
        end else if (i_addr == `OFS_PRIORITY) begin
          prio_bits <= i_wdata & 8'h06;
        end else if (i_addr == `OFS_T3_CTRL) begin
          second_timer_ctrl <= i_wdata;
        end else if (i_addr == `OFS_PERIOD) begin
          period_limit_reg <= i_wdata;
        end
      end
      flags[`FLAG_U1] <= match1 | (flags[`FLAG_U1] & ~(i_wr && i_addr == `OFS_FLAGS && !i_wdata[`FLAG_U1])); // (R03)
      flags[`FLAG_U2] <= match2 | (flags[`FLAG_U2] & ~(i_wr && i_addr == `OFS_FLAGS && !i_wdata[`FLAG_U2])); // (R03)
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // In PWM mode the high byte shows the live duty buffer
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      if (!i_rd) begin
        o_rdata <= 8'h00;
      end else if (i_addr == `OFS_U1_VAL_LO) begin
        o_rdata <= u1_lo;
      end else if (i_addr == `OFS_U1_VAL_HI) begin
        o_rdata <= pwm1 ? buf1 : u1_hi;
      end else if (i_addr == `OFS_U1_CTRL) begin
        o_rdata <= unit1_control_reg;
      end else if (i_addr == `OFS_U2_VAL_LO) begin
        o_rdata <= unit2_duty_low_byte;
      end else if (i_addr == `OFS_U2_VAL_HI) begin
        o_rdata <= pwm2 ? buf2 : u2_hi;
      end else if (i_addr == `OFS_U2_CTRL) begin
        o_rdata <= unit2_control_reg;
      end else if (i_addr == `OFS_FLAGS) begin
        o_rdata <= flags;
      end else if (i_addr == `OFS_ENABLES) begin
        o_rdata <= enables;
      end else if (i_addr == `OFS_PRIORITY) begin
        o_rdata <= prio_bits;
      end else if (i_addr == `OFS_T3_CTRL) begin
        o_rdata <= second_timer_ctrl;
      end else if (i_addr == `OFS_PERIOD) begin
        o_rdata <= period_limit_reg;
      end else if (i_addr == `OFS_PTIMER) begin
        o_rdata <= period_timer;
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end
endmodule // ccp_compare_and_pwm

// [ccp_consts.vh]
// Register map, field positions, mode codes and reset values of the compare/PWM block
`ifndef CCP_CONSTS_VH
`define CCP_CONSTS_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_U1_VAL_LO 4'h0
`define OFS_U1_VAL_HI 4'h1
`define OFS_U1_CTRL 4'h2
`define OFS_U2_VAL_LO 4'h3
`define OFS_U2_VAL_HI 4'h4
`define OFS_U2_CTRL 4'h5
`define OFS_FLAGS 4'h6
`define OFS_ENABLES 4'h7
`define OFS_PRIORITY 4'h8
`define OFS_T3_CTRL 4'h9
`define OFS_PERIOD 4'hA
`define OFS_PTIMER 4'hB
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_DUTY_HI 5
`define CTRL_DUTY_LO 4
`define FLAG_U1 1
`define FLAG_U2 2
`define T3_SEL_HI 6
`define T3_SEL_LO 3
// ----------------------------------------------------------------
// Mode codes of the 4-bit mode field
// ----------------------------------------------------------------
`define MODE_OFF 4'h0
`define MODE_SET_HIGH 4'h8
`define MODE_SET_LOW 4'h9
`define MODE_SOFT_IRQ 4'hA
`define MODE_SPECIAL 4'hB
`define MODE_TOGGLE 4'h2
`define MODE_PWM 4'hC
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_PERIOD 8'hFF
`endif

// [ccp_compare_unit.v]
// One compare channel: match detect, pin action and special trigger
`timescale 1ns/1ps
module ccp_compare_unit (
  input wire i_clk_sys, // System clock
  input wire i_rst_n, // Sync reset, active low
  input wire i_ce, // Clock enable
  input wire [3:0] i_mode, // Mode field
  input wire i_ctrl_zero, // Control register written with zero
  input wire [15:0] i_value, // Compare value
  input wire [15:0] i_timer, // Selected time base count
  output wire o_match, // Match event pulse
  output wire o_trigger, // Special trigger pulse
  output reg o_latch // Compare output latch
);
`include "ccp_consts.vh"

  reg matched;
  wire hit;
  wire cmp_mode;

  // Compare modes are the upper half of the code space plus toggle
  assign cmp_mode = i_mode[3] | (i_mode == `MODE_TOGGLE);
  assign hit = cmp_mode && (i_mode != `MODE_PWM) && (i_value == i_timer); // (R01)
  // Edge of the equality so a stalled timer fires once, not every cycle
  assign o_match = hit & ~matched & i_ce;
  assign o_trigger = o_match & (i_mode == `MODE_SPECIAL); // (R07)

  // Pin action on a match
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_latch <= 1'b0;
      matched <= 1'b0;
    end else if (i_ce) begin
      matched <= hit;
      if (i_ctrl_zero) begin
        o_latch <= 1'b0; // (R04)
      end else if (o_match) begin
        case (i_mode) // (R02) (R25)
          `MODE_SET_HIGH: o_latch <= 1'b1;
          `MODE_SET_LOW: o_latch <= 1'b0;
          `MODE_TOGGLE: o_latch <= ~o_latch;
          default: o_latch <= o_latch; // (R06)
        endcase
      end
    end
  end
endmodule // ccp_compare_unit

// [ccp_pwm_unit.v]
// One PWM channel: double-buffered 10-bit duty and output latch
`timescale 1ns/1ps
module ccp_pwm_unit (
  input wire i_clk_sys, // System clock
  input wire i_rst_n, // Sync reset, active low
  input wire i_ce, // Clock enable
  input wire i_enable, // Channel in PWM mode
  input wire i_ctrl_zero, // Control register written with zero
  input wire [9:0] i_duty, // Software duty value
  input wire i_rollover, // Period restart pulse
  input wire [9:0] i_count, // Period timer with 2 low phase or prescaler bits
  output reg [7:0] o_duty_buf, // Buffered duty high bits
  output reg o_pin // PWM output latch
);
  reg [1:0] duty_buf_lo;
  wire [9:0] duty_cur;

  assign duty_cur = {o_duty_buf, duty_buf_lo}; // (R18)

  // Buffer reload and pin set/clear
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_duty_buf <= 8'h00;
      duty_buf_lo <= 2'h0;
      o_pin <= 1'b0;
    end else if (i_ce) begin
      if (i_ctrl_zero) begin
        o_pin <= 1'b0;
      end else if (i_enable && i_rollover) begin
        o_duty_buf <= i_duty[9:2]; // (R14)
        duty_buf_lo <= i_duty[1:0]; // (R17)
        o_pin <= (i_duty != 10'h000); // (R13)
      end else if (i_enable && duty_cur == i_count) begin
        o_pin <= 1'b0; // (R19) (R20) (R16)
      end
    end
  end
endmodule // ccp_pwm_unit

// [ccp_compare_and_pwm_chk.sv]
// Port-level assertions for the compare/PWM top
`timescale 1ns/1ps
`include "ccp_consts.vh"
module ccp_compare_and_pwm_chk #(
  parameter PRESCALE = 1 // Same as top
) (
  input wire i_clk_sys, // Clock
  input wire i_rst_n, // Reset
  input wire i_ce, // Enable
  input wire [3:0] i_addr, // Address
  input wire [7:0] i_wdata, // Data
  input wire i_wr, // Write
  input wire i_rd, // Read
  input wire [7:0] o_rdata, // Read data
  input wire [15:0] i_timer1, // Timer
  input wire [15:0] i_timer3, // Timer
  input wire i_adc_enabled, // Converter on
  input wire i_port_latch1, // Latch
  input wire i_port_latch2, // Latch
  input wire o_timer1_reset, // Trigger
  input wire o_timer3_reset, // Trigger
  input wire o_adc_start, // Start
  input wire o_irq, // Request
  input wire o_first_unit, // Pin
  input wire o_second_unit // Pin
);
  reg [3:0] m1;
  reg [3:0] m2;
  reg sh;
  reg sl;
  reg p1;
  reg p2;
  reg [15:0] v1;
  reg [15:0] v2;
  reg [2:1] en;
  // Time base choice and first-match detect, shadowed from bus writes
  wire e1 = v1 == (sh ? i_timer3 : i_timer1);
  wire e2 = v2 == ((sh | sl) ? i_timer3 : i_timer1);
  wire f1 = e1 & ~p1 & i_ce;
  wire f2 = e2 & ~p2 & i_ce;
  wire wc1 = i_wr & (i_addr == `OFS_U1_CTRL);
  wire wc2 = i_wr & (i_addr == `OFS_U2_CTRL);
  wire b1 = m1 == `MODE_SPECIAL;
  wire b2 = m2 == `MODE_SPECIAL;
  // Shadow registers; stale after PWM, so only compare modes lean on them
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      {m1, m2, sh, sl, p1, p2, en} <= 14'h0000;
      v1 <= 16'h0000;
      v2 <= 16'h0000;
    end else if (i_ce) begin
      p1 <= e1;
      p2 <= e2;
      if (i_wr) begin
        case (i_addr)
          `OFS_U1_VAL_LO: v1[7:0] <= i_wdata;
          `OFS_U1_VAL_HI: if (m1 != `MODE_PWM) v1[15:8] <= i_wdata;
          `OFS_U1_CTRL: m1 <= i_wdata[3:0];
          `OFS_U2_VAL_LO: v2[7:0] <= i_wdata;
          `OFS_U2_VAL_HI: if (m2 != `MODE_PWM) v2[15:8] <= i_wdata;
          `OFS_U2_CTRL: m2 <= i_wdata[3:0];
          `OFS_ENABLES: en <= i_wdata[2:1];
          `OFS_T3_CTRL: {sh, sl} <= {i_wdata[`T3_SEL_HI], i_wdata[`T3_SEL_LO]};
          default: ;
        endcase
      end
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_trig_first: assert property (i_ce |-> o_timer1_reset == ((f1 & ~sh & b1) | (f2 & ~(sh | sl) & b2)))
    else $error("first timer reset wrong");
  a_trig_second: assert property (i_ce |-> o_timer3_reset == ((f1 & sh & b1) | (f2 & (sh | sl) & b2)))
    else $error("second timer reset wrong");
  a_adc_second_only: assert property (i_ce |-> o_adc_start == (f2 & b2 & i_adc_enabled))
    else $error("conversion start wrong");
  a_flag_sets_irq: assert property ((f1 && en[1] && (m1 == `MODE_SET_HIGH || m1 == `MODE_TOGGLE)) |=> o_irq)
    else $error("match did not raise request");
  a_irq_gated: assert property (en == 2'b00 |-> !o_irq)
    else $error("request without enable");
  a_pin_high: assert property ((f1 && m1 == `MODE_SET_HIGH && !wc1) |=> o_first_unit)
    else $error("pin not driven high");
  a_pin_low: assert property ((f2 && m2 == `MODE_SET_LOW && !wc2) |=> !o_second_unit)
    else $error("pin not driven low");
  a_pin_toggle: assert property ((f1 && m1 == `MODE_TOGGLE && !wc1) |=> o_first_unit != $past(o_first_unit))
    else $error("pin not toggled");
  a_soft_pin_kept: assert property ((f2 && m2 == `MODE_SOFT_IRQ && !wc2)
    |=> ($stable(o_second_unit) || !$stable(i_port_latch2)))
    else $error("soft mode moved pin");
  a_zero_ctrl_off: assert property ((i_ce && wc1 && i_wdata == 8'h00) |=> o_first_unit == i_port_latch1)
    else $error("zero control not off");
  c_trig_adc: cover property (f2 && b2 && i_adc_enabled);
  c_trig_second: cover property (o_timer3_reset);
  c_pwm_rise: cover property ($rose(o_second_unit) && m2 == `MODE_PWM);
endmodule // ccp_compare_and_pwm_chk

bind ccp_compare_and_pwm ccp_compare_and_pwm_chk #(.PRESCALE(PRESCALE)) chk_i (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer1(i_timer1), .i_timer3(i_timer3),
  .i_adc_enabled(i_adc_enabled), .i_port_latch1(i_port_latch1), .i_port_latch2(i_port_latch2),
  .o_timer1_reset(o_timer1_reset), .o_timer3_reset(o_timer3_reset), .o_adc_start(o_adc_start),
  .o_irq(o_irq), .o_first_unit(o_first_unit), .o_second_unit(o_second_unit));

// [pwm_meter.sv]
// Pin-side meter: high cycles and rising edges inside a window
`timescale 1ns/1ps
module pwm_meter (
  input wire i_clk_sys, // Clock
  input wire i_rst_n, // Reset
  input wire i_win, // Counting window
  input wire i_pin, // Driven pin
  output reg [15:0] o_hi, // High cycles
  output reg [15:0] o_rises // Rising edges
);
  reg last;
  reg wl;
  // Pin is taken as a driven output with no pull; window start restarts counts
  always @(posedge i_clk_sys) begin
    last <= i_pin;
    wl <= i_win;
    if (!i_rst_n) begin
      o_hi <= 16'h0000;
      o_rises <= 16'h0000;
    end else if (i_win) begin
      o_hi <= (wl ? o_hi : 16'h0000) + {15'h0000, i_pin};
      o_rises <= (wl ? o_rises : 16'h0000) + {15'h0000, i_pin & ~last};
    end
  end
endmodule // pwm_meter

// [testbench.sv]
// Self-checking bench of the compare/PWM block with pin meters
`timescale 1ns/1ps
`include "ccp_consts.vh"
module testbench;
  reg i_clk_sys = 1'b0;
  reg i_rst_n = 1'b0;
  reg [3:0] i_addr = 4'h0;
  reg [7:0] i_wdata = 8'h00;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg [15:0] i_timer1 = 16'h0000;
  reg [15:0] i_timer3 = 16'h0000;
  reg i_adc_enabled = 1'b0;
  reg i_port_latch1 = 1'b0;
  reg i_port_latch2 = 1'b0;
  reg win = 1'b0;
  reg [7:0] seed = 8'h18;
  reg [7:0] rdv;
  wire [7:0] o_rdata;
  wire o_timer1_reset, o_timer3_reset, o_adc_start, o_irq, o_first_unit, o_second_unit;
  wire [15:0] hi1, hi2, rs1, rs2;
  integer n_fail = 0;
  integer tests_run = 0;
  integer u, k;
  // ----------------------------------------------------------------
  // Design, pin meters, clock
  // ----------------------------------------------------------------
  ccp_compare_and_pwm #(.PRESCALE(1)) DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(1'b1),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_timer1(i_timer1), .i_timer3(i_timer3), .i_adc_enabled(i_adc_enabled),
    .i_port_latch1(i_port_latch1), .i_port_latch2(i_port_latch2), .o_timer1_reset(o_timer1_reset),
    .o_timer3_reset(o_timer3_reset), .o_adc_start(o_adc_start), .o_irq(o_irq),
    .o_first_unit(o_first_unit), .o_second_unit(o_second_unit));
  pwm_meter meter_a (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_win(win), .i_pin(o_first_unit),
    .o_hi(hi1), .o_rises(rs1));
  pwm_meter meter_b (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_win(win), .i_pin(o_second_unit),
    .o_hi(hi2), .o_rises(rs2));
  initial forever #5 i_clk_sys = ~i_clk_sys;
  // Helpers: random source, expected high time, mode table
  function [7:0] lfsr(input [7:0] x);
    lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function integer exp_hi(input integer d, input integer p);
    exp_hi = (d >= p) ? p : d;
  endfunction
  function [3:0] mode_of(input integer n);
    case (n)
      0: mode_of = `MODE_SET_HIGH;
      1: mode_of = `MODE_SET_LOW;
      2: mode_of = `MODE_TOGGLE;
      3: mode_of = `MODE_SOFT_IRQ;
      default: mode_of = `MODE_SPECIAL;
    endcase
  endfunction
  task conclude;
    begin
      $display("Counts: %0d checks, %0d mismatches", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Bus cycles: an idle cycle follows each strobe so no signal is set twice at one edge
  task wr(input [3:0] a, input [7:0] d);
    begin
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      @(posedge i_clk_sys);
    end
  endtask
  task rd(input [3:0] a, output [7:0] d);
    begin
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      @(posedge i_clk_sys);
      d = o_rdata;
    end
  endtask
  task wait_rise;
    integer i;
    reg p;
    begin
      p = 1'b1;
      for (i = 0; i < 1100 && !(p === 1'b0 && o_second_unit === 1'b1); i = i + 1) begin
        p = o_second_unit;
        @(posedge i_clk_sys);
      end
      if (i == 1100) begin
        chk("pwm_edge", 16'h0001, 16'h0000);
        conclude;
      end
    end
  endtask
  // One compare match on one unit with a chosen time base
  task cmp_case(input integer un, input [3:0] md, input integer sl);
    reg t3;
    reg [3:0] b;
    reg [15:0] v;
    begin
      t3 = (sl == 2) || (sl == 1 && un == 2);
      b = (un == 1) ? `OFS_U1_VAL_LO : `OFS_U2_VAL_LO;
      seed = lfsr(seed);
      v = {seed, lfsr(seed)};
      i_adc_enabled <= (md == `MODE_SPECIAL) | seed[0];
      i_port_latch1 <= seed[1];
      i_port_latch2 <= seed[2];
      i_timer1 <= v + 16'h0005;
      i_timer3 <= v + 16'h0005;
      wr(`OFS_T3_CTRL, (sl == 2) ? 8'h40 : (sl == 1) ? 8'h08 : 8'h00);
      wr(`OFS_ENABLES, (md == `MODE_SOFT_IRQ) ? 8'h00 : 8'h06);
      wr(b + 4'h2, 8'h00);
      wr(b, v[7:0]);
      wr(b + 4'h1, v[15:8]);
      wr(b + 4'h2, {4'h0, md});
      if (t3) i_timer3 <= v;
      else i_timer1 <= v;
      #1;
      chk("t1_reset", md == `MODE_SPECIAL && !t3, o_timer1_reset);
      chk("t3_reset", md == `MODE_SPECIAL && t3, o_timer3_reset);
      chk("adc_start", md == `MODE_SPECIAL && un == 2, o_adc_start);
      @(posedge i_clk_sys);
      #1;
      chk("irq", md != `MODE_SOFT_IRQ, o_irq);
      if (md == `MODE_SET_HIGH || md == `MODE_SET_LOW || md == `MODE_TOGGLE)
        chk("pin", md != `MODE_SET_LOW, (un == 1) ? o_first_unit : o_second_unit);
      @(posedge i_clk_sys);
      rd(`OFS_FLAGS, rdv);
      chk("flag", 8'h01 << un, rdv);
      wr(`OFS_FLAGS, 8'h00);
      rd(`OFS_FLAGS, rdv);
      chk("no_refire", 8'h00, rdv);
      if (md == `MODE_SET_HIGH && un == 1) begin
        wr(b + 4'h2, 8'h00);
        chk("port_pin", seed[1], o_first_unit);
        wr(b + 4'h2, {4'h0, md});
        chk("latch_low", 1'b0, o_first_unit);
      end
    end
  endtask
  // Both units in PWM on the shared period timer, measured over two periods
  task pwm_case(input [7:0] lim, input [9:0] da, input [9:0] db);
    integer pr;
    begin
      pr = 4 * (lim + 1);
      wr(`OFS_PERIOD, lim);
      wr(`OFS_U1_VAL_LO, da[9:2]);
      wr(`OFS_U1_CTRL, {2'b00, da[1:0], `MODE_PWM});
      wr(`OFS_U2_VAL_LO, db[9:2]);
      wr(`OFS_U2_CTRL, {2'b00, db[1:0], `MODE_PWM});
      repeat (1100 + 2 * pr) @(posedge i_clk_sys);
      win <= 1'b1;
      repeat (2 * pr) @(posedge i_clk_sys);
      win <= 1'b0;
      @(posedge i_clk_sys);
      chk("high_a", 2 * exp_hi(da, pr), hi1);
      chk("high_b", 2 * exp_hi(db, pr), hi2);
      chk("rises_b", (db == 0 || db >= pr) ? 0 : 2, rs2);
      chk("rises_a", (da == 0 || da >= pr) ? 0 : 2, rs1);
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    rd(`OFS_PERIOD, rdv);
    chk("period_rst", 8'hFF, rdv);
    rd(4'hF, rdv);
    chk("unmapped", 8'h00, rdv);
    wr(`OFS_U1_CTRL, 8'hFF);
    rd(`OFS_U1_CTRL, rdv);
    chk("ctrl_bits", 8'h3F, rdv);
    wr(`OFS_U1_CTRL, 8'h00);
    $display("test registers done");
    for (u = 1; u < 3; u = u + 1)
      for (k = 0; k < 5; k = k + 1)
        cmp_case(u, mode_of(k), (k + u) % 3);
    $display("test compare done");
    pwm_case(8'h01, 10'h004, 10'h008);
    pwm_case(8'h03, 10'h000, 10'h00D);
    pwm_case(8'h03, 10'h3FF, 10'h001);
    seed = lfsr(seed);
    pwm_case(8'h3F, {2'b00, seed}, {2'b00, lfsr(seed)});
    $display("test pwm done");
    wr(`OFS_PERIOD, 8'hFF);
    wr(`OFS_U2_VAL_LO, 8'h40);
    wait_rise;
    wait_rise;
    wr(`OFS_U2_VAL_LO, 8'h80);
    wr(`OFS_U2_VAL_HI, 8'h55);
    rd(`OFS_U2_VAL_HI, rdv);
    chk("buf_held", 8'h40, rdv);
    wait_rise;
    rd(`OFS_U2_VAL_HI, rdv);
    chk("buf_loaded", 8'h80, rdv);
    $display("test buffer done");
    conclude;
  end
endmodule // testbench
